// ===== logic/timer_pkg.sv
package timer_pkg;

  // register port geometry
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;

  // register offsets
  localparam logic [3:0] OFS_CNT_HI   = 4'h0;
  localparam logic [3:0] OFS_CNT_LO   = 4'h1;
  localparam logic [3:0] OFS_RLD_HI   = 4'h2;
  localparam logic [3:0] OFS_RLD_LO   = 4'h3;
  localparam logic [3:0] OFS_CTL0     = 4'h4;
  localparam logic [3:0] OFS_CTL1     = 4'h5;
  localparam logic [3:0] OFS_CAPT_HI  = 4'h6;
  localparam logic [3:0] OFS_CAPT_LO  = 4'h7;
  localparam logic [3:0] OFS_IRQ_REQ0 = 4'h8;

  // control zero fields
  localparam int CTL_EN      = 7;
  localparam int CTL_POL     = 6;
  localparam int CTL_PRE_HI  = 5;
  localparam int CTL_PRE_LO  = 3;
  localparam int CTL_OUTLVL  = 2;
  localparam int CTL_MODE_HI = 1;
  localparam int CTL_MODE_LO = 0;

  // control one field: interrupt source select
  localparam int ISS_HI = 1;
  localparam int ISS_LO = 0;
  localparam logic [1:0] ISS_CAPTURE = 2'h2;
  localparam logic [1:0] ISS_RELOAD  = 2'h3;

  // interrupt request zero bit positions
  localparam int IRQ_FIRST_BIT  = 5;
  localparam int IRQ_SECOND_BIT = 6;
  localparam logic [7:0] IRQ_MASK = 8'h60;

  // reset values and counter constants
  localparam logic [7:0]  CTL0_RST   = 8'h00;
  localparam logic [7:0]  CTL1_RST   = 8'h00;
  localparam logic [15:0] CNT_RST    = 16'h0000;
  localparam logic [15:0] RLD_RST    = 16'hFFFF;
  localparam logic [15:0] CNT_ONE    = 16'h0001;
  localparam logic [15:0] CNT_ALL1   = 16'hFFFF;
  localparam logic [7:0]  BYTE_ZERO  = 8'h00;

  typedef enum logic [1:0] {
    MODE_COMPARE,
    MODE_GATED,
    MODE_CAPCMP,
    MODE_DUAL_PWM
  } mode_t;

endpackage : timer_pkg

// ===== logic/mode_timer.sv
// Strobed register access and the register offsets were left to the implementer.
`timescale 1ns/1ps
module mode_timer (
  input  wire logic                         SYS_CLK,
  input  wire logic                         RESET_N,
  input  wire logic [timer_pkg::ADDR_W-1:0] ADDR,
  input  wire logic [timer_pkg::DATA_W-1:0] WDATA,
  input  wire logic                         WR,
  input  wire logic                         RD,
  output logic      [timer_pkg::DATA_W-1:0] RDATA,
  input  wire logic                         TIO_IN,
  input  wire logic                         IN_ALT_SEL,
  input  wire logic                         SECOND_TIMER_EVT,
  output logic                              TOUT,
  output logic                              TIO_OUT,
  output logic                              TIO_OE,
  output logic      [timer_pkg::DATA_W-1:0] IRQ_REQ
);
  import timer_pkg::*;

  logic        rst_meta_r;
  logic        rst_n_r;
  logic [7:0]  ctl0_r;
  logic [7:0]  ctl1_r;
  logic [15:0] cnt_r;
  logic [15:0] cnt_nxt;
  logic [15:0] rld_r;
  logic [15:0] capt_r;
  logic [7:0]  hold_r;
  logic [6:0]  presc_r;
  logic [6:0]  presc_nxt;
  logic        tin_prev_r;
  logic        started_r;
  logic        tout_r;
  logic        tout_nxt;
  logic        tio_out_r;
  logic        tio_oe_r;
  logic [7:0]  irq_r;
  logic [7:0]  irq_nxt;
  logic [7:0]  rdata_r;
  logic [7:0]  rdata_nxt;

  // reset release through two flops
  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      rst_meta_r <= 1'b0;
      rst_n_r    <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n_r    <= rst_meta_r;
    end
  end

  // register port decode
  wire wr_cnt_hi = WR && (ADDR == OFS_CNT_HI);
  wire wr_cnt_lo = WR && (ADDR == OFS_CNT_LO);
  wire wr_cnt    = wr_cnt_hi || wr_cnt_lo;
  wire wr_rld_hi = WR && (ADDR == OFS_RLD_HI);
  wire wr_rld_lo = WR && (ADDR == OFS_RLD_LO);
  wire wr_ctl0   = WR && (ADDR == OFS_CTL0);
  wire wr_ctl1   = WR && (ADDR == OFS_CTL1);
  wire wr_irq    = WR && (ADDR == OFS_IRQ_REQ0);
  wire rd_cnt_hi = RD && (ADDR == OFS_CNT_HI);
  wire rd_cnt_lo = RD && (ADDR == OFS_CNT_LO);

  // control fields
  wire        en      = ctl0_r[CTL_EN];
  wire        input_polarity_bit    = ctl0_r[CTL_POL];
  wire [2:0]  pre_sel = ctl0_r[CTL_PRE_HI:CTL_PRE_LO];
  wire mode_t mode    = mode_t'(ctl0_r[CTL_MODE_HI:CTL_MODE_LO]);
  wire [1:0]  iss     = ctl1_r[ISS_HI:ISS_LO];
  wire        m_cmp   = (mode == MODE_COMPARE);
  wire        m_gate  = (mode == MODE_GATED);
  wire        m_cap   = (mode == MODE_CAPCMP);
  wire        m_dual  = (mode == MODE_DUAL_PWM);

  // input pin level; no timer input in dual pwm mode
  wire tin        = (IN_ALT_SEL && !m_dual) ? TIO_IN : !input_polarity_bit;
  wire active     = (tin == input_polarity_bit);
  wire was_active = (tin_prev_r == input_polarity_bit);
  wire rise       = tin && !tin_prev_r;
  wire fall       = !tin && tin_prev_r;
  wire cap_edge   = input_polarity_bit ? rise : fall;

  // prescaler terminal count, divide by two to the select
  wire [7:0] presc_div  = 8'(8'h01 << pre_sel);
  wire [6:0] presc_lim  = 7'(presc_div - 8'h01);
  wire       presc_last = (presc_r == presc_lim);
  wire       tick       = en && presc_last;

  // which modes may count on this tick
  wire count_ok = m_cmp || m_dual || (m_gate && active)
                  || (m_cap && started_r);
  wire step      = tick && count_ok;
  wire cnt_match = (cnt_r == rld_r);

  // timer events
  wire cmp_evt    = step && cnt_match && m_cmp;
  wire reload_evt = step && cnt_match && !m_cmp;
  wire gate_end   = en && m_gate && was_active && !active;
  wire first_edge = en && m_cap && !started_r && cap_edge;
  wire capt_evt   = en && m_cap && started_r && cap_edge;
  wire cap_irq_ok = (iss != ISS_RELOAD);
  wire rld_irq_ok = !m_cap || (iss != ISS_CAPTURE);
  wire timer_irq  = cmp_evt || gate_end
                    || (reload_evt && rld_irq_ok)
                    || (capt_evt && cap_irq_ok);
  wire toggle     = cmp_evt || reload_evt;

  // prescaler held at zero while disabled, restarts on enable
  always_comb begin
    if (!en || presc_last) begin
      presc_nxt = 7'h00;
    end else begin
      presc_nxt = presc_r + 7'h01;
    end
  end

  // counter: software write, reload to one, or increment
  always_comb begin
    cnt_nxt = cnt_r;
    if (wr_cnt_hi) begin
      cnt_nxt = {WDATA, cnt_r[7:0]};
    end else if (wr_cnt_lo) begin
      cnt_nxt = {cnt_r[15:8], WDATA};
    end else if (reload_evt) begin
      cnt_nxt = CNT_ONE;
    end else if (step) begin
      cnt_nxt = cnt_r + CNT_ONE;
    end
  end

  // output level: preset while disabled, toggle on compare match or reload
  always_comb begin
    tout_nxt = tout_r;
    if (wr_ctl0 && !WDATA[CTL_EN]) begin
      tout_nxt = WDATA[CTL_OUTLVL];
    end else if (toggle) begin
      tout_nxt = !tout_r;
    end
  end

  // pending bits: software write, then hardware set wins
  always_comb begin
    irq_nxt = wr_irq ? (WDATA & IRQ_MASK) : irq_r;
    if (timer_irq) begin
      irq_nxt[IRQ_FIRST_BIT] = 1'b1;
    end
    if (SECOND_TIMER_EVT) begin
      irq_nxt[IRQ_SECOND_BIT] = 1'b1;
    end
  end

  // read mux; unmapped offsets read zero
  always_comb begin
    rdata_nxt = BYTE_ZERO;
    if (RD) begin
      unique case (ADDR)
        OFS_CNT_HI:   rdata_nxt = cnt_r[15:8];
        OFS_CNT_LO:   rdata_nxt = en ? hold_r : cnt_r[7:0];
        OFS_RLD_HI:   rdata_nxt = rld_r[15:8];
        OFS_RLD_LO:   rdata_nxt = rld_r[7:0];
        OFS_CTL0:     rdata_nxt = ctl0_r;
        OFS_CTL1:     rdata_nxt = ctl1_r;
        OFS_CAPT_HI:  rdata_nxt = capt_r[15:8];
        OFS_CAPT_LO:  rdata_nxt = capt_r[7:0];
        OFS_IRQ_REQ0: rdata_nxt = irq_r;
        default:      rdata_nxt = BYTE_ZERO;
      endcase
    end
  end

  // software registers
  always_ff @(posedge SYS_CLK or negedge rst_n_r) begin
    if (!rst_n_r) begin
      ctl0_r <= CTL0_RST;
      ctl1_r <= CTL1_RST;
      rld_r  <= RLD_RST;
    end else begin
      if (wr_ctl0) ctl0_r <= WDATA;
      if (wr_ctl1) ctl1_r <= WDATA;
      if (wr_rld_hi) rld_r[15:8] <= WDATA;
      if (wr_rld_lo) rld_r[7:0] <= WDATA;
    end
  end

  // counting state
  always_ff @(posedge SYS_CLK or negedge rst_n_r) begin
    if (!rst_n_r) begin
      cnt_r      <= CNT_RST;
      presc_r    <= 7'h00;
      tin_prev_r <= 1'b0;
      started_r  <= 1'b0;
    end else begin
      cnt_r      <= cnt_nxt;
      presc_r    <= presc_nxt;
      tin_prev_r <= tin;
      started_r  <= en && m_cap && (started_r || first_edge);
    end
  end

  // capture and holding registers
  always_ff @(posedge SYS_CLK or negedge rst_n_r) begin
    if (!rst_n_r) begin
      capt_r <= CNT_RST;
      hold_r <= BYTE_ZERO;
    end else begin
      if (capt_evt) capt_r <= cnt_r;
      if (rd_cnt_hi && en) hold_r <= cnt_r[7:0];
    end
  end

  // registered outputs
  always_ff @(posedge SYS_CLK or negedge rst_n_r) begin
    if (!rst_n_r) begin
      tout_r    <= 1'b0;
      tio_out_r <= 1'b1;
      tio_oe_r  <= 1'b0;
      irq_r     <= BYTE_ZERO;
      rdata_r   <= BYTE_ZERO;
    end else begin
      tout_r    <= tout_nxt;
      tio_out_r <= !tout_nxt;
      tio_oe_r  <= IN_ALT_SEL && m_dual;
      irq_r     <= irq_nxt;
      rdata_r   <= rdata_nxt;
    end
  end

  assign RDATA   = rdata_r;
  assign TOUT    = tout_r;
  assign TIO_OUT = tio_out_r;
  assign TIO_OE  = tio_oe_r;
  assign IRQ_REQ = irq_r;

  // checks on the timer behaviour
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!rst_n_r);

  AST_CMP_NO_RELOAD: assert property (
    cmp_evt && !wr_cnt |=> cnt_r == $past(cnt_r) + CNT_ONE && irq_r[5])
    else $error("compare match did not count on with a request");

  AST_WRAP: assert property (
    step && m_cmp && cnt_r == CNT_ALL1 && !wr_cnt |=> cnt_r == CNT_RST)
    else $error("count did not wrap to zero");

  AST_PRESCALE_HOLD: assert property (
    en && m_cmp && !presc_last && !wr_cnt |=> $stable(cnt_r))
    else $error("count moved between prescaler ticks");

  AST_GATE_HOLD: assert property (
    en && m_gate && !active && !wr_cnt |=> $stable(cnt_r))
    else $error("gated count moved while input inactive");

  AST_GATE_END: assert property (
    gate_end |=> irq_r[5])
    else $error("gate release raised no request");

  AST_RELOAD_ONE: assert property (
    reload_evt && !wr_cnt |=> cnt_r == CNT_ONE)
    else $error("reload did not set count to one");

  AST_CAP_ONLY: assert property (
    m_cap && iss == ISS_CAPTURE && reload_evt && !capt_evt |-> !timer_irq)
    else $error("reload requested in capture-only setting");

  AST_FIRST_EDGE: assert property (
    first_edge |-> !timer_irq ##1 started_r)
    else $error("first edge mishandled");

  AST_HOLD_READ: assert property (
    rd_cnt_hi && en ##1 rd_cnt_lo && en |=> RDATA == $past(cnt_r[7:0], 2))
    else $error("low byte read did not return held value");

  AST_LIVE_READ: assert property (
    rd_cnt_lo && !en |=> RDATA == $past(cnt_r[7:0]))
    else $error("disabled low byte read not live");

  AST_TOGGLE: assert property (
    toggle && !wr_ctl0 |=> TOUT != $past(TOUT))
    else $error("output did not toggle");

  AST_PENDING: assert property (
    timer_irq |=> IRQ_REQ[5])
    else $error("pending bit not set");

  AST_CAPTURE: assert property (
    capt_evt |=> capt_r == $past(cnt_r))
    else $error("capture did not store count");

  AST_GATE_RLD_IRQ: assert property (
    reload_evt && m_gate |=> irq_r[IRQ_FIRST_BIT])
    else $error("gated reload raised no request");

  AST_GATE_COUNT: assert property (
    tick && m_gate && active && !cnt_match && !wr_cnt
    |=> cnt_r == $past(cnt_r) + CNT_ONE)
    else $error("gated count did not step while input active");

  AST_CAP_WAIT: assert property (
    en && m_cap && !started_r && !wr_cnt |=> $stable(cnt_r))
    else $error("capture count moved before first edge");

  AST_RLD_ONLY: assert property (
    m_cap && iss == ISS_RELOAD && capt_evt && !reload_evt |-> !timer_irq)
    else $error("capture requested in reload-only setting");

  AST_PRESC_RESTART: assert property (
    !en |=> presc_r == 7'h00)
    else $error("prescaler not held at zero while disabled");

  AST_NO_INPUT: assert property (
    !IN_ALT_SEL && en && m_gate && !wr_cnt |=> $stable(cnt_r))
    else $error("gated count moved with input not selected");

  AST_PIN_COMPLEMENT: assert property (
    TIO_OUT != TOUT)
    else $error("pin output not complement of timer output");

  AST_PIN_DRIVE: assert property (
    !IN_ALT_SEL || !m_dual |=> !TIO_OE)
    else $error("pin driven outside dual output mode");

  AST_SECOND_PENDING: assert property (
    SECOND_TIMER_EVT |=> IRQ_REQ[IRQ_SECOND_BIT])
    else $error("other timer request not pending");

endmodule : mode_timer

// ===== verification/tio_partner.sv
`timescale 1ns/1ps
module tio_partner (
  input  wire logic drive_lvl,
  input  wire logic oe,
  input  wire logic out_lvl,
  output logic      pin
);
  // far side level unless the timer drives the shared pin
  assign pin = oe ? out_lvl : drive_lvl;
endmodule : tio_partner

// ===== verification/test_sixteen_bit_mode_timer.sv
`timescale 1ns/1ps
module test_sixteen_bit_mode_timer;
  import timer_pkg::*;
  logic              sys_clk, reset_n, wr, rd, alt_sel, evt, lvl, a;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata, rdata, irq_req, d;
  logic              tout, tio_out, tio_oe, pin;
  logic [15:0]       c, h;
  int                n_mismatch, num_checks, i;

  mode_timer u_dut (.SYS_CLK(sys_clk), .RESET_N(reset_n), .ADDR(addr),
    .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata), .TIO_IN(pin),
    .IN_ALT_SEL(alt_sel), .SECOND_TIMER_EVT(evt), .TOUT(tout),
    .TIO_OUT(tio_out), .TIO_OE(tio_oe), .IRQ_REQ(irq_req));
  tio_partner u_pin (.drive_lvl(lvl), .oe(tio_oe), .out_lvl(tio_out),
    .pin(pin));

  // clock source
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  task automatic chk(input string nm, input logic [15:0] seen, exp);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  function automatic logic inr(input logic [15:0] v, lo, hi);
    return (v >= lo) && (v <= hi);
  endfunction : inr

  task automatic wr_reg(input logic [3:0] ad, input logic [7:0] v);
    @(posedge sys_clk);
    wr <= 1'b1;
    addr <= ad;
    wdata <= v;
    @(posedge sys_clk);
    wr <= 1'b0;
  endtask : wr_reg

  task automatic rd_reg(input logic [3:0] ad, output logic [7:0] v);
    @(posedge sys_clk);
    rd <= 1'b1;
    addr <= ad;
    @(posedge sys_clk);
    rd <= 1'b0;
    #1 v = rdata;
  endtask : rd_reg

  // high byte first, so a running count reads coherently
  task automatic rd_cnt(input logic [3:0] ad, output logic [15:0] v);
    logic [7:0] hi, lo;
    rd_reg(ad, hi);
    rd_reg(ad + 4'h1, lo);
    v = {hi, lo};
  endtask : rd_cnt

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : wait_cyc

  task automatic set_lvl(input logic v);
    @(posedge sys_clk);
    lvl <= v;
  endtask : set_lvl

  task automatic wait_irq;
    for (int j = 0; j < 60 && irq_req[IRQ_FIRST_BIT] !== 1'b1; j++)
      wait_cyc(1);
  endtask : wait_irq

  // configure disabled, load count and reload, then enable
  task automatic setup(input logic [7:0] ctl, input logic [15:0] cn, rl,
                       input logic [1:0] iss);
    wr_reg(OFS_CTL0, ctl & 8'h7F);
    wr_reg(OFS_CNT_HI, cn[15:8]);
    wr_reg(OFS_CNT_LO, cn[7:0]);
    wr_reg(OFS_RLD_HI, rl[15:8]);
    wr_reg(OFS_RLD_LO, rl[7:0]);
    wr_reg(OFS_CTL1, {6'h00, iss});
    wr_reg(OFS_IRQ_REQ0, BYTE_ZERO);
    wr_reg(OFS_CTL0, ctl);
  endtask : setup

  task automatic final_report;
    if (n_mismatch == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : final_report

  // watchdog against a hang
  initial begin
    #400000;
    n_mismatch++;
    final_report;
  end

  initial begin
    n_mismatch = 0;
    num_checks = 0;
    {reset_n, wr, rd, evt, lvl} = 5'h00;
    addr = 4'h0;
    wdata = 8'h00;
    alt_sel = 1'b1;
    repeat (4) @(posedge sys_clk);
    reset_n <= 1'b1;
    wait_cyc(4);
    // reset values, offset 9 unmapped
    chk("tout", {tout, tio_out}, 16'h0001);
    for (i = 0; i < 10; i++) begin
      rd_reg(i[3:0], d);
      chk("reset", d, (i == 2 || i == 3) ? 8'hFF : 8'h00);
    end
    // compare match keeps counting and toggles output
    setup(8'h80, 16'h0000, 16'h0005, 2'h0);
    wait_irq;
    chk("cmp irq", irq_req, 8'h20);
    chk("cmp tout", tout, 1'b1);
    wait_cyc(10);
    wr_reg(OFS_CTL0, 8'h00);
    rd_cnt(OFS_CNT_HI, c);
    chk("cmp cnt", inr(c, 16'h000F, 16'h0014), 1'b1);
    // prescale by 4, pin toggling must not count
    setup(8'h90, 16'h0000, 16'hFFFF, 2'h0);
    for (i = 0; i < 100; i++)
      set_lvl(~lvl);
    wr_reg(OFS_CTL0, 8'h00);
    rd_cnt(OFS_CNT_HI, c);
    chk("pre cnt", inr(c, 16'h0017, 16'h001A), 1'b1);
    // wrap from all ones
    setup(8'h80, 16'hFFFD, 16'h0100, 2'h0);
    wait_cyc(10);
    wr_reg(OFS_CTL0, 8'h00);
    rd_cnt(OFS_CNT_HI, c);
    chk("wrap", inr(c, 16'h0004, 16'h000C), 1'b1);
    // held low byte versus live count, prescale 128
    setup(8'hB8, 16'h0000, 16'hFFFF, 2'h0);
    wait_cyc(700);
    rd_reg(OFS_CNT_HI, d);
    wait_cyc(600);
    rd_reg(OFS_CNT_LO, h[7:0]);
    wr_reg(OFS_CTL0, 8'h00);
    rd_reg(OFS_CNT_LO, c[7:0]);
    chk("hold", inr(c[7:0] - h[7:0], 16'h0004, 16'h0005), 1'b1);
    wr_reg(OFS_CNT_LO, 8'h3C);
    rd_reg(OFS_CNT_LO, d);
    chk("live lo", d, 8'h3C);
    // gated: idle input, short pulse, then reload
    setup(8'hC1, 16'h0001, 16'h0008, 2'h0);
    wait_cyc(20);
    rd_cnt(OFS_CNT_HI, c);
    chk("gate idle", {irq_req, c[7:0]}, 16'h0001);
    set_lvl(1'b1);
    wait_cyc(3);
    set_lvl(1'b0);
    wait_cyc(5);
    chk("gate rel", irq_req, 8'h20);
    wr_reg(OFS_CTL0, 8'h00);
    rd_cnt(OFS_CNT_HI, c);
    chk("gate cnt", inr(c, 16'h0004, 16'h0006), 1'b1);
    set_lvl(1'b1);
    setup(8'hC1, 16'h0001, 16'h0008, 2'h0);
    wait_irq;
    chk("gate tout", {irq_req, 7'h00, tout}, 16'h2001);
    wait_cyc(3);
    wr_reg(OFS_CTL0, 8'h00);
    rd_cnt(OFS_CNT_HI, c);
    chk("gate rld", inr(c, 16'h0002, 16'h0007), 1'b1);
    // capture: rising iss 0, falling iss 2, rising iss 3
    for (i = 0; i < 3; i++) begin
      a = (i != 1);
      set_lvl(~a);
      setup(a ? 8'hC2 : 8'h82, 16'h0001, 16'h0028, {|i[1:0], i[1]});
      wait_cyc(20);
      rd_cnt(OFS_CNT_HI, c);
      chk("cap wait", c, CNT_ONE);
      set_lvl(a);
      wait_cyc(10);
      chk("cap first", irq_req, 8'h00);
      set_lvl(~a);
      wait_cyc(10);
      set_lvl(a);
      wait_cyc(5);
      chk("cap irq", irq_req[IRQ_FIRST_BIT], i != 2);
      wr_reg(OFS_IRQ_REQ0, BYTE_ZERO);
      wait_cyc(15);
      chk("rld irq", irq_req[IRQ_FIRST_BIT], i != 1);
      wr_reg(OFS_CTL0, 8'h00);
      rd_cnt(OFS_CAPT_HI, c);
      chk("cap val", inr(c, 16'h0012, 16'h0018), 1'b1);
    end
    // other timer request sets its own bit
    @(posedge sys_clk);
    evt <= 1'b1;
    @(posedge sys_clk);
    evt <= 1'b0;
    rd_reg(OFS_IRQ_REQ0, d);
    chk("irq bit6", {d, irq_req}, 16'h6060);
    wr_reg(OFS_IRQ_REQ0, BYTE_ZERO);
    rd_reg(OFS_IRQ_REQ0, d);
    chk("irq clr", d, 8'h00);
    // dual pwm drives the shared pin with the complement
    setup(8'h83, 16'h0001, 16'h0010, 2'h0);
    wait_cyc(3);
    chk("pin oe", {tio_oe, tio_out ^ tout, pin ^ tio_out}, 3'h6);
    // input not selected: gated mode must not count
    set_lvl(1'b1);
    alt_sel <= 1'b0;
    setup(8'hC1, 16'h0001, 16'h0010, 2'h0);
    wait_cyc(10);
    chk("no alt oe", tio_oe, 1'b0);
    wr_reg(OFS_CTL0, 8'h00);
    rd_cnt(OFS_CNT_HI, c);
    chk("no alt", c, CNT_ONE);
    final_report;
  end
endmodule : test_sixteen_bit_mode_timer
